// file: rtl/sfc_map.svh
// offsets, field positions, opcodes and reset values of the command front end
// assumes inclusion by its bare name from the design file
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// pin positions inside the sampled pin vector
`define SFC_PIN_SI       0
`define SFC_PIN_SCK      1
`define SFC_PIN_CS       2

// opcodes
`define SFC_OP_WREN      8'h06
`define SFC_OP_WRDI      8'h04
`define SFC_OP_RDSR1     8'h05
`define SFC_OP_RDSR2     8'h35
`define SFC_OP_RDSR3     8'h15
`define SFC_OP_WRSR1     8'h01
`define SFC_OP_WRSR2     8'h31
`define SFC_OP_WRSR3     8'h11
`define SFC_OP_RDEAR     8'hc8
`define SFC_OP_WREAR     8'hc5
`define SFC_OP_VOLWE     8'h50
`define SFC_OP_WRAP      8'h77
`define SFC_OP_CE_A      8'hc7
`define SFC_OP_CE_B      8'h60
`define SFC_OP_EN4B      8'hb7
`define SFC_OP_EX4B      8'he9
`define SFC_OP_PP        8'h02
`define SFC_OP_PP4       8'h12

// status register: reset value and writable bits of each byte
`define SFC_SR_RESET     24'h200200
`define SFC_SR1_WMASK    8'hfc
`define SFC_SR2_WMASK    8'hfe
`define SFC_SR3_WMASK    8'hf3
// power-up address width bit inside the high status byte
`define SFC_ADP_BIT      4
// byte index of the wrap setting byte within a frame
`define SFC_WRAP_BYTE    3'h4
`define SFC_WRAP_RESET   8'hff
`define SFC_ADDR3        3'h3
`define SFC_ADDR4        3'h4

`endif

// file: rtl/sfc_pkg.sv
// types of the serial flash command front end
// assumes sfc_map.svh is on the include path
`default_nettype none

package sfc_pkg;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } sfc_status_t;

  typedef struct packed {
    logic chipErase;
    logic pageProgram;
    logic addrValid;
  } sfc_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPC  = 4'b0010,
    ST_IN   = 4'b0100,
    ST_OUT  = 4'b1000
  } sfc_state_t;

endpackage

`default_nettype wire

// file: rtl/sfc_front_end.sv
// command front end of a serial nor flash: framing, opcode decode, status
// and extended address registers. assumes one system clock that samples the
// serial link pins; the host keeps the serial clock no faster than clock/8.
//
// Contract
// - extended address byte holds upper address bit in bit 0, others reserved.
// - upper bit applies only in 3-byte mode, changed only by C5H.
// - 3-byte mode maps to low or high 16 MB by upper bit.
// - in 4-byte mode four address bytes expected, upper bit ignored.
// - msb first, bits sampled on rising serial clock after select falls.
// - frame is one opcode byte then address and or data bytes.
// - reads shift data out; host may stop after any bit.
// - write-type commands run only if select rises on byte boundary.
// - page program with incomplete byte does nothing, keeps write latch.
// - 06H sets and 04H clears the write latch, no arguments.
// - 05H, 35H, 15H return status bytes, repeating while clocked.
// - 01H, 31H, 11H write one byte to the status bytes.
// - C8H reads and C5H writes the extended address byte.
// - 50H is volatile status write enable, no arguments.
// - 77H takes wrap setting from the fifth byte.
// - C7H or 60H is chip erase, no arguments.
// - E9H returns to 3-byte address mode.
// - read-only address mode flag, 0 for 3-byte, 1 for 4-byte.
// - after reset mode follows the power-up address width bit.
// - status writes, program and erase refused while write latch clear; here status writes also run after 50H with the latch clear.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.svh"

module sfc_front_end
  import sfc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clockEnable,
  input  wire logic        linkSck,
  input  wire logic        linkCsN,
  input  wire logic        linkSi,
  output logic             linkSo,
  output logic             linkSoEn,
  output logic             currentAddrWidthFlag,
  output logic             writeLatchFlag,
  output logic [7:0]       extAddrByte,
  output logic [7:0]       wrapSettingByte,
  output logic [24:0]      arrayAddr,
  output sfc_req_t         req
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling: three flops, a change counts once stages two and three agree

  logic [2:0]  syn1;
  logic [2:0]  syn2;
  logic [2:0]  syn3;
  logic [2:0]  filt;
  logic [2:0]  filtPrev;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      syn1     <= 3'h7;
      syn2     <= 3'h7;
      syn3     <= 3'h7;
      filt     <= 3'h6;
      filtPrev <= 3'h6;
    end else if (clockEnable) begin
      syn1     <= {linkCsN, linkSck, linkSi};
      syn2     <= syn1;
      syn3     <= syn2;
      filt     <= (syn2 & ~(syn2 ^ syn3)) | (filt & (syn2 ^ syn3));
      filtPrev <= filt;
    end
  end

  logic csHigh;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic siBit;

  assign csHigh  = filt[`SFC_PIN_CS];
  assign csRise  = filt[`SFC_PIN_CS] & ~filtPrev[`SFC_PIN_CS];
  assign sckRise = filt[`SFC_PIN_SCK] & ~filtPrev[`SFC_PIN_SCK] & ~csHigh;
  assign sckFall = ~filt[`SFC_PIN_SCK] & filtPrev[`SFC_PIN_SCK] & ~csHigh;
  assign siBit   = filt[`SFC_PIN_SI];

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic isRead(input logic [7:0] op);
    case (op)
      `SFC_OP_RDSR1, `SFC_OP_RDSR2, `SFC_OP_RDSR3, `SFC_OP_RDEAR: isRead = 1'b1;
      default: isRead = 1'b0;
    endcase
  endfunction

  // opcodes handled here carry no array address; all others are passed on
  function automatic logic isLocal(input logic [7:0] op);
    case (op)
      `SFC_OP_WREN, `SFC_OP_WRDI, `SFC_OP_WRSR1, `SFC_OP_WRSR2, `SFC_OP_WRSR3,
      `SFC_OP_RDEAR, `SFC_OP_WREAR, `SFC_OP_VOLWE, `SFC_OP_WRAP, `SFC_OP_CE_A,
      `SFC_OP_CE_B, `SFC_OP_EN4B, `SFC_OP_EX4B: isLocal = 1'b1;
      default: isLocal = isRead(op);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // framing

  sfc_state_t  state;
  logic [2:0]  bitCnt;
  logic [2:0]  byteCnt;
  logic [7:0]  shiftIn;
  logic [7:0]  opcode;
  logic [7:0]  firstData;
  logic [7:0]  wrapByte;
  logic [23:0] addrReg;
  logic [7:0]  next_byte;
  logic        byteDone;
  logic [2:0]  addrBytes;
  sfc_status_t status;
  logic        ext0;
  logic        volWe;

  assign next_byte = {shiftIn[6:0], siBit};
  assign byteDone  = sckRise & (bitCnt == 3'h7);
  assign addrBytes = currentAddrWidthFlag ? `SFC_ADDR4 : `SFC_ADDR3;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      bitCnt    <= 3'h0;
      byteCnt   <= 3'h0;
      shiftIn   <= 8'h00;
      opcode    <= 8'h00;
      firstData <= 8'h00;
      wrapByte  <= 8'h00;
      addrReg   <= 24'h000000;
    end else if (clockEnable) begin
      if (csHigh) begin
        state   <= ST_IDLE;
        bitCnt  <= 3'h0;
        byteCnt <= 3'h0;
      end else begin
        case (state)
          ST_IDLE: state <= ST_OPC;
          ST_OPC:  if (byteDone) begin
            state <= isRead(next_byte) ? ST_OUT : ST_IN;
          end
          ST_IN:   state <= ST_IN;
          ST_OUT:  state <= ST_OUT;
          default: state <= ST_IDLE;
        endcase
        if (sckRise) begin
          shiftIn <= next_byte;
          bitCnt  <= bitCnt + 3'h1;
        end
        if (byteDone) begin
          if (byteCnt != 3'h7) begin
            byteCnt <= byteCnt + 3'h1;
          end
          if (byteCnt == 3'h0) begin
            opcode <= next_byte;
          end
          if (byteCnt == 3'h1) begin
            firstData <= next_byte;
          end
          if (byteCnt == `SFC_WRAP_BYTE) begin
            wrapByte <= next_byte;
          end
          addrReg <= {addrReg[15:0], next_byte};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array address for commands passed on

  logic addrValidPulse;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      arrayAddr      <= 25'h0000000;
      addrValidPulse <= 1'b0;
    end else if (clockEnable) begin
      addrValidPulse <= 1'b0;
      if (byteDone && byteCnt == addrBytes && !isLocal(opcode)) begin
        addrValidPulse <= 1'b1;
        if (currentAddrWidthFlag) begin
          arrayAddr <= {addrReg[16:0], next_byte};
        end else begin
          arrayAddr <= {ext0, addrReg[15:0], next_byte};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution when select rises

  logic doExec;
  logic welOk;
  logic initPending;
  logic earWrite;
  logic erasePulse;
  logic programPulse;

  // every command here runs only on a byte boundary, not just the write-type ones;
  // a whole byte is needed, so an empty select pulse never replays a stale opcode
  assign doExec   = clockEnable & csRise & (bitCnt == 3'h0) & (byteCnt != 3'h0);
  assign welOk    = writeLatchFlag | volWe;
  assign earWrite = doExec & (opcode == `SFC_OP_WREAR);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status               <= `SFC_SR_RESET;
      writeLatchFlag       <= 1'b0;
      volWe                <= 1'b0;
      ext0                 <= 1'b0;
      wrapSettingByte      <= `SFC_WRAP_RESET;
      currentAddrWidthFlag <= 1'b0;
      initPending          <= 1'b1;
      erasePulse           <= 1'b0;
      programPulse         <= 1'b0;
    end else if (clockEnable) begin
      erasePulse   <= 1'b0;
      programPulse <= 1'b0;
      if (initPending) begin
        // the strap is caught one edge after release, never under reset
        initPending          <= 1'b0;
        currentAddrWidthFlag <= status.high[`SFC_ADP_BIT];
      end
      if (doExec) begin
        case (opcode)
          `SFC_OP_WREN: writeLatchFlag <= 1'b1;
          `SFC_OP_WRDI: writeLatchFlag <= 1'b0;
          `SFC_OP_VOLWE: volWe <= 1'b1;
          `SFC_OP_WRSR1: if (welOk && byteCnt >= 3'h2) begin
            status.low <= (status.low & ~`SFC_SR1_WMASK) | (firstData & `SFC_SR1_WMASK);
            writeLatchFlag <= 1'b0;
            volWe          <= 1'b0;
          end
          `SFC_OP_WRSR2: if (welOk && byteCnt >= 3'h2) begin
            status.mid <= (status.mid & ~`SFC_SR2_WMASK) | (firstData & `SFC_SR2_WMASK);
            writeLatchFlag <= 1'b0;
            volWe          <= 1'b0;
          end
          `SFC_OP_WRSR3: if (welOk && byteCnt >= 3'h2) begin
            status.high <= (status.high & ~`SFC_SR3_WMASK) | (firstData & `SFC_SR3_WMASK);
            writeLatchFlag <= 1'b0;
            volWe          <= 1'b0;
          end
          // reserved bits are dropped, so a host that ignores the advice is harmless
          `SFC_OP_WREAR: if (byteCnt >= 3'h2) begin
            ext0 <= firstData[0];
          end
          `SFC_OP_WRAP: if (byteCnt >= 3'h5) begin
            wrapSettingByte <= wrapByte;
          end
          `SFC_OP_CE_A, `SFC_OP_CE_B: if (writeLatchFlag) begin
            erasePulse     <= 1'b1;
            writeLatchFlag <= 1'b0;
          end
          `SFC_OP_PP, `SFC_OP_PP4: if (writeLatchFlag && byteCnt >= addrBytes + 3'h2) begin
            programPulse   <= 1'b1;
            writeLatchFlag <= 1'b0;
          end
          `SFC_OP_EN4B: currentAddrWidthFlag <= 1'b1;
          `SFC_OP_EX4B: currentAddrWidthFlag <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  assign extAddrByte = {7'h00, ext0};
  assign req         = {erasePulse, programPulse, addrValidPulse};

  ////////////////////////////////////////////////////////////////////////////
  // read data out, msb first, byte repeats while the clock runs

  logic [7:0] outByte;
  logic [7:0] readVal;
  logic       soHold;

  always_comb begin
    case (next_byte)
      `SFC_OP_RDSR1: readVal = {status.low[7:2], writeLatchFlag, 1'b0};
      `SFC_OP_RDSR2: readVal = {status.mid[7:1], currentAddrWidthFlag};
      `SFC_OP_RDSR3: readVal = status.high;
      `SFC_OP_RDEAR: readVal = {7'h00, ext0};
      default:       readVal = 8'h00;
    endcase
  end

  // first bit goes out at once after the opcode: the pin filter delays the
  // falling edge by several clocks and would cost the host setup margin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      outByte  <= 8'h00;
      linkSo   <= 1'b0;
      linkSoEn <= 1'b0;
      soHold   <= 1'b0;
    end else if (clockEnable) begin
      if (csHigh) begin
        linkSoEn <= 1'b0;
        linkSo   <= 1'b0;
        soHold   <= 1'b0;
      end else if (state == ST_OPC && byteDone && isRead(next_byte)) begin
        outByte  <= readVal;
        linkSo   <= readVal[7];
        linkSoEn <= 1'b1;
        soHold   <= 1'b1;
      end else if (state == ST_OUT && sckFall && soHold) begin
        // the fall right after the opcode keeps bit 7 for the host's next rise
        soHold <= 1'b0;
      end else if (state == ST_OUT && sckFall) begin
        outByte <= {outByte[6:0], outByte[7]};
        linkSo  <= outByte[6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  bit_clear_a: assert property (clockEnable && csHigh |=> bitCnt == 3'h0 && state == ST_IDLE)
    else $error("bit counter not cleared while deselected");
  wel_set_a: assert property (doExec && opcode == `SFC_OP_WREN |=> writeLatchFlag)
    else $error("write enable did not set the latch");
  wel_clear_a: assert property (doExec && opcode == `SFC_OP_WRDI |=> !writeLatchFlag)
    else $error("write disable did not clear the latch");
  mode_enter_a: assert property (doExec && opcode == `SFC_OP_EN4B |=> currentAddrWidthFlag)
    else $error("enter 4-byte mode ignored");
  mode_exit_a: assert property (doExec && opcode == `SFC_OP_EX4B |=> !currentAddrWidthFlag)
    else $error("exit 4-byte mode ignored");
  ext_only_c5_a: assert property (!initPending && $changed(ext0) |-> $past(earWrite))
    else $error("upper address bit changed without C5H");
  erase_gate_a: assert property ((req.chipErase || req.pageProgram) |-> $past(writeLatchFlag) && !writeLatchFlag)
    else $error("erase or program without write latch");
  partial_keep_a: assert property (clockEnable && csRise && bitCnt != 3'h0 && writeLatchFlag |=> writeLatchFlag)
    else $error("partial byte altered the write latch");
  upper_map_a: assert property (req.addrValid && !currentAddrWidthFlag |-> arrayAddr[24] == ext0)
    else $error("upper address bit not applied in 3-byte mode");
  so_repeat_a: assert property (clockEnable && state == ST_OUT && sckFall && !csHigh && !soHold |=> linkSo == $past(outByte[6]))
    else $error("status output bit out of order");
  so_first_a: assert property (clockEnable && state == ST_OUT && sckFall && soHold |=> $stable(linkSo))
    else $error("first output bit left before the host sampled it");
  so_release_a: assert property (clockEnable && csHigh |=> !linkSoEn)
    else $error("output still driven while deselected");

  wel_cover_c: cover property (doExec && opcode == `SFC_OP_WREN);
  read_cover_c: cover property (state == ST_OUT && sckFall);
  erase_cover_c: cover property (req.chipErase);
  addr_cover_c: cover property (req.addrValid && currentAddrWidthFlag);

endmodule

`default_nettype wire

// file: verif/sfc_host_model.sv
// host controller model: frames commands on the serial link, mode 0
// assumes the bench clock; a serial clock period is 8 clocks, still between frames
`timescale 1ns/10ps
`default_nettype none

module sfc_host_model (
  input  wire logic clock,
  input  wire logic linkSo,
  output logic      linkSck,
  output logic      linkCsN,
  output logic      linkSi
);
  initial begin
    linkSck = 1'b0;
    linkCsN = 1'b1;
    linkSi  = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sends the top n bits of d; rd keeps the last 8 bits seen on so
  task automatic frame(input logic [47:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clock);
    linkCsN <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      linkSi <= d[47 - i];
      repeat (4) @(posedge clock);
      linkSck <= 1'b1;
      repeat (3) @(posedge clock);
      // so moves after the fall, so take it late in the high phase
      @(negedge clock);
      rd = {rd[6:0], linkSo};
      @(posedge clock);
      linkSck <= 1'b0;
    end
    repeat (4) @(posedge clock);
    linkCsN <= 1'b1;
    // released line shows the inverse so a stale value never passes
    linkSi  <= ~linkSi;
    repeat (12) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// file: verif/testbench.sv
// bench of the command front end: the host model drives the link
// assumes rtl/ and sfc_host_model are compiled first
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import sfc_pkg::*;
  logic        clock;
  logic        reset_n;
  logic        clockEnable;
  logic        linkSck;
  logic        linkCsN;
  logic        linkSi;
  logic        linkSo;
  logic        linkSoEn;
  logic        modeFlag;
  logic        latch;
  logic [7:0]  extAddrByte;
  logic [7:0]  wrapByte;
  logic [24:0] arrayAddr;
  sfc_req_t    req;
  logic [7:0]  v;
  int          n_mismatch, cmp_count, ceCount, ppCount, avCount, cycles;

  sfc_front_end u_dut (
    .clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
    .linkSck(linkSck), .linkCsN(linkCsN), .linkSi(linkSi),
    .linkSo(linkSo), .linkSoEn(linkSoEn), .currentAddrWidthFlag(modeFlag),
    .writeLatchFlag(latch), .extAddrByte(extAddrByte),
    .wrapSettingByte(wrapByte), .arrayAddr(arrayAddr), .req(req)
  );
  sfc_host_model u_host (
    .clock(clock), .linkSo(linkSo), .linkSck(linkSck),
    .linkCsN(linkCsN), .linkSi(linkSi)
  );

  always #12.5 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (req.chipErase === 1'b1) ceCount++;
    if (req.pageProgram === 1'b1) ppCount++;
    if (req.addrValid === 1'b1) avCount++;
    if (cycles == 90000) begin
      n_mismatch++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // d is right-aligned: its low n bits go out msb first
  task automatic send(input logic [47:0] d, input int n);
    logic [7:0] r;
    u_host.frame(d << (48 - n), n, r);
  endtask

  task automatic rd(input logic [7:0] op, input int n, output logic [7:0] r);
    u_host.frame({op, 40'h0}, n, r);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(25'(modeFlag), 25'h0);
    chk(25'(extAddrByte), 25'h0);
    chk(25'(wrapByte), 25'hff);
    chk(25'(linkSoEn), 25'h0);
    rd(8'h05, 16, v);
    chk(25'(v), 25'h00);
    rd(8'h35, 16, v);
    chk(25'(v), 25'h02);
    rd(8'h15, 16, v);
    chk(25'(v), 25'h20);
    rd(8'hc8, 16, v);
    chk(25'(v), 25'h00);
    $display("test reset done");
  endtask

  task automatic t_latch();
    send(48'h06, 8);
    chk(25'(latch), 25'h1);
    rd(8'h05, 24, v);
    chk(25'(v), 25'h02);
    send(48'h04, 8);
    chk(25'(latch), 25'h0);
    send(48'h03, 7);
    chk(25'(latch), 25'h0);
    send(48'h0c, 9);
    chk(25'(latch), 25'h0);
    // the 9-bit frame left 06H captured: an empty select pulse must not replay it
    send(48'h00, 0);
    chk(25'(latch), 25'h0);
    $display("test latch done");
  endtask

  task automatic t_status();
    send(48'h01ff, 16);
    rd(8'h05, 16, v);
    chk(25'(v), 25'h00);
    send(48'h06, 8);
    send(48'h01ff, 16);
    rd(8'h05, 16, v);
    chk(25'(v), 25'hfc);
    send(48'h50, 8);
    send(48'h31ff, 16);
    rd(8'h35, 16, v);
    chk(25'(v), 25'hfe);
    send(48'h06, 8);
    send(48'h114c, 16);
    rd(8'h15, 24, v);
    chk(25'(v), 25'h40);
    $display("test status done");
  endtask

  task automatic t_ext();
    int a;
    send(48'hc501, 16);
    chk(25'(extAddrByte), 25'h01);
    rd(8'hc8, 16, v);
    chk(25'(v), 25'h01);
    a = avCount;
    send(48'h03123456, 32);
    chk(arrayAddr, 25'h1123456);
    chk(25'(avCount - a), 25'h1);
    send(48'hc500, 16);
    send(48'h03123456, 32);
    chk(arrayAddr, 25'h0123456);
    send(48'hc501, 16);
    send(48'h06, 8);
    send(48'h04, 8);
    chk(25'(extAddrByte), 25'h01);
    $display("test extended address done");
  endtask

  task automatic t_wide();
    send(48'hb7, 8);
    chk(25'(modeFlag), 25'h1);
    rd(8'h35, 16, v);
    chk(25'(v), 25'hff);
    send(48'h0300abcdef, 40);
    chk(arrayAddr, 25'h0abcdef);
    send(48'he9, 8);
    chk(25'(modeFlag), 25'h0);
    chk(25'(extAddrByte), 25'h01);
    $display("test address mode done");
  endtask

  task automatic t_wrap();
    send(48'h770000003c, 40);
    chk(25'(wrapByte), 25'h3c);
    send(48'h77000000, 32);
    chk(25'(wrapByte), 25'h3c);
    // a sixth byte after the wrap setting is ignored
    send(48'h77000000a5ff, 48);
    chk(25'(wrapByte), 25'ha5);
    $display("test wrap done");
  endtask

  task automatic t_erase();
    int c;
    c = ceCount;
    send(48'hc7, 8);
    chk(25'(ceCount - c), 25'h0);
    send(48'h06, 8);
    send(48'hc7, 8);
    chk(25'(ceCount - c), 25'h1);
    send(48'h06, 8);
    send(48'h60, 8);
    chk(25'(ceCount - c), 25'h2);
    send(48'h06, 8);
    send(48'({40'h02123456aa, 3'b000}), 43);
    chk(25'(ppCount), 25'h0);
    chk(25'(latch), 25'h1);
    send(48'h02123456aa, 40);
    chk(25'(ppCount), 25'h1);
    $display("test erase and program done");
  endtask

  task automatic t_abort();
    send(48'h04, 8);
    rd(8'h05, 12, v);
    chk(25'(linkSoEn), 25'h0);
    send(48'h06, 8);
    chk(25'(latch), 25'h1);
    $display("test abort done");
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    clockEnable = 1'b1;
    {n_mismatch, cmp_count, ceCount, ppCount, avCount, cycles} = '0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_reset();
    t_latch();
    t_status();
    t_ext();
    t_wide();
    t_wrap();
    t_erase();
    t_abort();
    close_out();
  end
endmodule

`default_nettype wire
